// File: remap_defines.vh
// Purpose: Constants shared by the peripheral remap matrix files.
// Assumes: Byte addresses on a 12-bit register port with 32-bit data.
// Notes: Definitions only; no logic lives here.
`ifndef REMAP_DEFINES_VH
`define REMAP_DEFINES_VH

// ==========================================================
// Register map
`define ADDR_W 12
`define IN_FIRST 12'h000
`define IN_LAST 12'h05C
`define OUT_FIRST 12'h100
`define OUT_LAST 12'h17C
`define CFG_ADDR 12'h200
`define DCW3_ADDR 12'h204

// ==========================================================
// Fields and sizes
`define SEL_W 4
`define NUM_IN 24
`define NUM_PINS 32
`define NUM_SRC 16
`define LOCK_BIT 13
`define ONE_WAY_BIT 29
`define IN_SEL_RESET 4'hF
`define OUT_SEL_RESET 4'h0
`define LOCK_RESET 1'b0
`define ONE_WAY_RESET 1'b1
`define FUSE_SETTLE 3'h5

// ==========================================================
// Input groups: first input index of groups 1, 2 and 3.
`define GRP1_FIRST 5
`define GRP2_FIRST 11
`define GRP3_FIRST 19
// Highest valid input code of group 0.
`define GRP0_IN_MAX 3'h6

// ==========================================================
// Peripheral inputs that idle high (slave selects, clear-to-send, receive).
`define IN_IDLE 24'h41_8308
// Pins present only on the largest package.
`define LARGE_ONLY 32'hC020_E020
// Pins absent on the smallest package.
`define SMALL_ABSENT 32'h20C0_0040
`define PKG_SMALL 44'd28
`define PKG_MID 44'd36

`endif

// File: pin_sync.v
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to clock.
// Notes: The output moves only when stages two and three agree.
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
	parameter W = 32
) (
	// Clock and reset.
	input wire clock,
	input wire sys_rst,
	// Asynchronous level in, filtered level out.
	input wire [W-1:0] async_in,
	output reg [W-1:0] level_out
);

	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	reg [W-1:0] s3_r;

	// ==========================================================
	// Only the second stage reads the first, so metastability stays contained.
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s1_r <= {W{1'b0}};
			s2_r <= {W{1'b0}};
			s3_r <= {W{1'b0}};
			level_out <= {W{1'b0}};
		end else begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// Agreeing stages pass their level; disagreeing stages hold the old output.
			level_out <= (s2_r & s3_r) | (level_out & (s2_r ^ s3_r));
		end
	end

endmodule
`default_nettype wire

// File: peripheral_pin_remap_lock.v
// Purpose: Run-time peripheral remap matrix with write lock.
// Assumes: One 250 MHz clock; pins and the fuse level are asynchronous.
// Notes: Routed signals are registered, adding latency beyond the pin sync.
// How it works
// (RQ1) Separate input and output selector sets, programmed independently.
// (RQ2) Each peripheral input has a 4-bit selector choosing its driving pin.
// (RQ3) Group 0 inputs: codes 0-6 pick A0,B3,B4,B15,B7,C7,C0; rest reserved.
// (RQ4) Group 1 inputs: codes 0-7 pick A1,B5,B1,B11,B8,A8,C8,A9.
// (RQ5) Group 2 inputs: codes 0-7 pick A2,B6,A4,B13,B2,C6,C1,C3.
// (RQ6) Group 3 inputs: codes 0-7 pick A3,B14,B0,B10,B9,C9,C2,C4.
// (RQ7) Each pin has a 4-bit selector naming the peripheral output it carries.
// (RQ8) Output code zero, the reset value, connects nothing.
// (RQ9) Group 0 pins: 1 uart1 tx, 2 uart2 rts, 3 spi1 select, 5 compare 1.
// (RQ10) Group 1 pins: 3 spi1 out, 4 spi2 out, 5 compare 2, 7 comparator 3.
// (RQ11) Group 2 pins: 3 spi1 out, 4 spi2 out, 5/6 compare 4/5, 7 refclk.
// (RQ12) Group 3 pins: 1 uart1 rts, 2 uart2 tx, 4 spi2 select, 5 compare 3, 7 comp 1.
// (RQ13) Selector writes while locked complete but change nothing.
// (RQ14) Lock is bit 13 of the config control register.
// (RQ15) Software runs the unlock sequence before changing the lock.
// (RQ16) With the one-way option set, the lock cannot clear until reset.
// (RQ17) The one-way option reads set when unprogrammed.
// (RQ18) Pins missing on the chosen package select nothing.
// (RQ19) Remapped peripheral beats other digital functions, never analog.
// (RQ20) No default pin: everything unconnected until programmed.
// (RQ21) Reserved input code holds the peripheral input at its idle level.
// (RQ22) Reserved output code behaves like no-connect.
`timescale 1ns/1ns
`default_nettype none
`include "remap_defines.vh"

module peripheral_pin_remap_lock #(
	parameter PACKAGE_PINS = 44
) (
	// Clock and reset.
	input wire clock,
	input wire sys_rst,
	// Register port.
	input wire [11:0] bus_addr,
	input wire [31:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	output reg [31:0] bus_rdata,
	// System unlock state and the one-way fuse level.
	input wire system_unlocked,
	input wire one_way_fuse,
	// Pins and the other functions sharing them.
	input wire [31:0] pin_in,
	input wire [31:0] gpio_out,
	input wire [31:0] gpio_oe,
	input wire [31:0] analog_sel,
	output reg [31:0] pin_out,
	output reg [31:0] pin_oe,
	// Peripheral outputs to be routed onto pins.
	input wire uart1_transmit,
	input wire uart2_request_to_send,
	input wire spi1_slave_select_out,
	input wire compare_output1,
	input wire spi1_data_out,
	input wire spi2_data_out,
	input wire compare_output2,
	input wire comparator3_output,
	input wire compare_output4,
	input wire compare_output5,
	input wire reference_clock_out,
	input wire uart1_request_to_send,
	input wire uart2_transmit,
	input wire spi2_slave_select_out,
	input wire compare_output3,
	input wire comparator1_output,
	// Peripheral inputs fed from pins.
	output wire ext_irq4_input,
	output wire timer2_clock_in,
	output wire capture4_in,
	output wire spi1_slave_select,
	output wire reference_clock_in,
	output wire ext_irq3_input,
	output wire timer3_clock_in,
	output wire capture3_in,
	output wire uart1_clear_to_send,
	output wire uart2_receive,
	output wire spi1_data_in,
	output wire ext_irq2_input,
	output wire timer4_clock_in,
	output wire capture1_in,
	output wire capture5_in,
	output wire uart1_receive,
	output wire uart2_clear_to_send,
	output wire spi2_data_in,
	output wire compare_fault_b,
	output wire ext_irq1_input,
	output wire timer5_clock_in,
	output wire capture2_in,
	output wire spi2_slave_select,
	output wire compare_fault_a
);

	// ==========================================================
	// Package pin availability, fixed at build time.
	localparam [31:0] PIN_AVAIL = (PACKAGE_PINS <= `PKG_SMALL) ? ~(`LARGE_ONLY | `SMALL_ABSENT) :
		(PACKAGE_PINS <= `PKG_MID) ? ~`LARGE_ONLY : 32'hFFFF_FFFF; // see (RQ18)

	reg [`NUM_IN*`SEL_W-1:0] in_sel_r;
	reg [`NUM_PINS*`SEL_W-1:0] out_sel_r;
	reg remap_write_lock_r;
	reg one_way_lock_option_r;
	reg [2:0] settle_r;
	reg [`NUM_IN-1:0] periph_in_r;
	reg [`NUM_IN-1:0] periph_in_nxt;
	reg [31:0] pin_out_nxt;
	reg [31:0] pin_oe_nxt;
	reg [31:0] rdata_nxt;
	reg [1:0] pick;
	reg [4:0] idx;
	wire [31:0] pin_level;
	wire fuse_level;
	wire [`NUM_SRC-1:0] src;
	wire in_hit;
	wire out_hit;
	wire [4:0] in_idx;
	wire [4:0] out_idx;
	wire [11:0] in_off;
	wire [11:0] out_off;
	integer i;
	integer j;

	// ==========================================================
	// Input group of a peripheral input index.
	function [1:0] in_grp;
		input integer n;
		begin
			if (n < `GRP1_FIRST)
				in_grp = 2'h0;
			else if (n < `GRP2_FIRST)
				in_grp = 2'h1;
			else if (n < `GRP3_FIRST)
				in_grp = 2'h2;
			else
				in_grp = 2'h3;
		end
	endfunction

	// Valid input codes: bit 3 clear, and group 0 stops short of code 7.
	function in_code_ok;
		input [1:0] grp;
		input [3:0] code;
		begin
			in_code_ok = !code[3] && !(grp == 2'h0 && code[2:0] > `GRP0_IN_MAX); // see (RQ3) (RQ21)
		end
	endfunction

	// Output selection per pin group: returns {active, level}.
	function [1:0] out_pick;
		input [1:0] grp;
		input [3:0] code;
		input [`NUM_SRC-1:0] s;
		begin
			case ({grp, code})
				6'h01: out_pick = {1'b1, s[0]}; // see (RQ9)
				6'h02: out_pick = {1'b1, s[1]}; // see (RQ9)
				6'h03: out_pick = {1'b1, s[2]}; // see (RQ9)
				6'h05: out_pick = {1'b1, s[3]}; // see (RQ9)
				6'h13: out_pick = {1'b1, s[4]}; // see (RQ10)
				6'h14: out_pick = {1'b1, s[5]}; // see (RQ10)
				6'h15: out_pick = {1'b1, s[6]}; // see (RQ10)
				6'h17: out_pick = {1'b1, s[7]}; // see (RQ10)
				6'h23: out_pick = {1'b1, s[4]}; // see (RQ11)
				6'h24: out_pick = {1'b1, s[5]}; // see (RQ11)
				6'h25: out_pick = {1'b1, s[8]}; // see (RQ11)
				6'h26: out_pick = {1'b1, s[9]}; // see (RQ11)
				6'h27: out_pick = {1'b1, s[10]}; // see (RQ11)
				6'h31: out_pick = {1'b1, s[11]}; // see (RQ12)
				6'h32: out_pick = {1'b1, s[12]}; // see (RQ12)
				6'h34: out_pick = {1'b1, s[13]}; // see (RQ12)
				6'h35: out_pick = {1'b1, s[14]}; // see (RQ12)
				6'h37: out_pick = {1'b1, s[15]}; // see (RQ12)
				default: out_pick = 2'b00; // see (RQ8) (RQ22)
			endcase
		end
	endfunction

	// ==========================================================
	// Pin and fuse synchronisation.
	pin_sync #(
		.W(33)
	) u_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.async_in({one_way_fuse, pin_in}),
		.level_out({fuse_level, pin_level})
	);

	assign src = {comparator1_output, compare_output3, spi2_slave_select_out, uart2_transmit,
		uart1_request_to_send, reference_clock_out, compare_output5, compare_output4,
		comparator3_output, compare_output2, spi2_data_out, spi1_data_out,
		compare_output1, spi1_slave_select_out, uart2_request_to_send, uart1_transmit};

	// ==========================================================
	// Address decode; misaligned or out-of-range addresses hit nothing.
	assign in_off = bus_addr - `IN_FIRST;
	assign out_off = bus_addr - `OUT_FIRST;
	assign in_idx = in_off[6:2];
	assign out_idx = out_off[6:2];
	assign in_hit = bus_addr <= `IN_LAST && bus_addr[1:0] == 2'b00;
	assign out_hit = bus_addr >= `OUT_FIRST && bus_addr <= `OUT_LAST && bus_addr[1:0] == 2'b00;

	// ==========================================================
	// Selector registers. Inputs reset to a reserved code so no pin feeds them.
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			in_sel_r <= {`NUM_IN{`IN_SEL_RESET}}; // see (RQ20)
			out_sel_r <= {`NUM_PINS{`OUT_SEL_RESET}}; // see (RQ8)
		end else if (bus_wr && !remap_write_lock_r) begin // see (RQ13)
			if (in_hit)
				in_sel_r[in_idx*`SEL_W +: `SEL_W] <= bus_wdata[`SEL_W-1:0]; // see (RQ1) (RQ2)
			if (out_hit)
				out_sel_r[out_idx*`SEL_W +: `SEL_W] <= bus_wdata[`SEL_W-1:0]; // see (RQ1) (RQ7)
		end
	end

	// ==========================================================
	// Lock bit. A change needs the system unlock state; with the one-way
	// option a set lock can only be cleared by reset.
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			remap_write_lock_r <= `LOCK_RESET;
		end else if (bus_wr && bus_addr == `CFG_ADDR && system_unlocked) begin // see (RQ15)
			if (bus_wdata[`LOCK_BIT])
				remap_write_lock_r <= 1'b1; // see (RQ14)
			else if (!one_way_lock_option_r)
				remap_write_lock_r <= 1'b0; // see (RQ14) (RQ16)
		end
	end

	// ==========================================================
	// The fuse is caught once, after the synchroniser has settled; until
	// then the option reads as set, its unprogrammed state.
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			settle_r <= 3'h0;
			one_way_lock_option_r <= `ONE_WAY_RESET; // see (RQ17)
		end else if (settle_r != `FUSE_SETTLE) begin
			settle_r <= settle_r + 3'h1;
			if (settle_r + 3'h1 == `FUSE_SETTLE)
				one_way_lock_option_r <= fuse_level; // see (RQ16)
		end
	end

	// ==========================================================
	// Read mux; unmapped addresses and reserved bits read zero.
	always @* begin
		rdata_nxt = 32'h0000_0000;
		if (in_hit)
			rdata_nxt[`SEL_W-1:0] = in_sel_r[in_idx*`SEL_W +: `SEL_W];
		else if (out_hit)
			rdata_nxt[`SEL_W-1:0] = out_sel_r[out_idx*`SEL_W +: `SEL_W];
		else if (bus_addr == `CFG_ADDR)
			rdata_nxt[`LOCK_BIT] = remap_write_lock_r;
		else if (bus_addr == `DCW3_ADDR)
			rdata_nxt[`ONE_WAY_BIT] = one_way_lock_option_r; // see (RQ17)
	end

	// Read data stand for exactly the cycle after the strobe.
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			bus_rdata <= 32'h0000_0000;
		else if (bus_rd)
			bus_rdata <= rdata_nxt;
		else
			bus_rdata <= 32'h0000_0000;
	end

	// ==========================================================
	// Input routing. A reserved code, a missing pin or an analog pin leaves
	// the peripheral at its idle level so it never sees a false edge.
	always @* begin
		periph_in_nxt = `IN_IDLE;
		idx = 5'h00;
		for (i = 0; i < `NUM_IN; i = i + 1) begin
			idx = {in_grp(i), in_sel_r[i*`SEL_W +: 3]}; // see (RQ3) (RQ4) (RQ5) (RQ6)
			if (in_code_ok(in_grp(i), in_sel_r[i*`SEL_W +: `SEL_W]) && PIN_AVAIL[idx] && !analog_sel[idx])
				periph_in_nxt[i] = pin_level[idx]; // see (RQ2) (RQ18) (RQ19) (RQ21)
		end
	end

	// ==========================================================
	// Output routing. Analog ownership wins; then a remapped peripheral;
	// then the ordinary port output.
	always @* begin
		pin_out_nxt = 32'h0000_0000;
		pin_oe_nxt = 32'h0000_0000;
		pick = 2'b00;
		for (j = 0; j < `NUM_PINS; j = j + 1) begin
			pick = out_pick(j[4:3], out_sel_r[j*`SEL_W +: `SEL_W], src); // see (RQ7)
			if (analog_sel[j]) begin
				pin_out_nxt[j] = 1'b0; // see (RQ19)
				pin_oe_nxt[j] = 1'b0;
			end else if (pick[1] && PIN_AVAIL[j]) begin
				pin_out_nxt[j] = pick[0]; // see (RQ19) (RQ18)
				pin_oe_nxt[j] = 1'b1;
			end else begin
				pin_out_nxt[j] = gpio_out[j]; // see (RQ8) (RQ22)
				pin_oe_nxt[j] = gpio_oe[j];
			end
		end
	end

	// ==========================================================
	// Routed data leave from flip-flops; peripheral inputs reset idle.
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			periph_in_r <= `IN_IDLE; // see (RQ20)
			pin_out <= 32'h0000_0000;
			pin_oe <= 32'h0000_0000;
		end else begin
			periph_in_r <= periph_in_nxt;
			pin_out <= pin_out_nxt;
			pin_oe <= pin_oe_nxt;
		end
	end

	// Peripheral input fan-out, in selector index order.
	assign ext_irq4_input = periph_in_r[0];
	assign timer2_clock_in = periph_in_r[1];
	assign capture4_in = periph_in_r[2];
	assign spi1_slave_select = periph_in_r[3];
	assign reference_clock_in = periph_in_r[4];
	assign ext_irq3_input = periph_in_r[5];
	assign timer3_clock_in = periph_in_r[6];
	assign capture3_in = periph_in_r[7];
	assign uart1_clear_to_send = periph_in_r[8];
	assign uart2_receive = periph_in_r[9];
	assign spi1_data_in = periph_in_r[10];
	assign ext_irq2_input = periph_in_r[11];
	assign timer4_clock_in = periph_in_r[12];
	assign capture1_in = periph_in_r[13];
	assign capture5_in = periph_in_r[14];
	assign uart1_receive = periph_in_r[15];
	assign uart2_clear_to_send = periph_in_r[16];
	assign spi2_data_in = periph_in_r[17];
	assign compare_fault_b = periph_in_r[18];
	assign ext_irq1_input = periph_in_r[19];
	assign timer5_clock_in = periph_in_r[20];
	assign capture2_in = periph_in_r[21];
	assign spi2_slave_select = periph_in_r[22];
	assign compare_fault_a = periph_in_r[23];

endmodule
`default_nettype wire

// File: far_side_model.sv
// Purpose: Model of the peripherals and pads that face the remap matrix.
// Assumes: The bench sets the levels it wants each source to present.
// Notes: Pad levels are asynchronous to the block clock.
`timescale 1ns/1ns
`default_nettype none

module far_side_model (
	// Levels requested by the bench.
	input wire logic [15:0] src_lv,
	input wire logic [31:0] pad_lv,
	// Levels presented to the block.
	output logic [15:0] periph_out,
	output logic [31:0] pad_in
);
	// ==========================================================
	// Sources
	// Peripheral outputs and pads hold their level until the bench changes it.
	assign periph_out = src_lv;
	assign pad_in = pad_lv;
endmodule

`default_nettype wire

// File: remap_monitor.sv
// Purpose: Port-level assertions for the peripheral remap matrix.
// Assumes: One clock domain, reset active high.
// Notes: Bound to the top module and watches only its ports.
`timescale 1ns/1ns
`default_nettype none

module remap_monitor (
	// Clock and reset.
	input wire logic clock,
	input wire logic sys_rst,
	// Register port.
	input wire logic [11:0] bus_addr,
	input wire logic bus_rd,
	input wire logic [31:0] bus_rdata,
	// Pin side.
	input wire logic [31:0] gpio_oe,
	input wire logic [31:0] analog_sel,
	input wire logic [31:0] pin_oe,
	// Peripheral inputs seen at reset exit.
	input wire logic spi1_slave_select,
	input wire logic uart1_receive,
	input wire logic ext_irq4_input
);
	// ==========================================================
	// Assertions
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	// Read data only stands in the cycle after a read strobe.
	a_rdata_quiet: assert property (!bus_rd |=> bus_rdata == 32'h0) else $error("read data outside read cycle");
	a_gap_read: assert property (bus_rd && (bus_addr == 12'h060 || bus_addr[1:0] != 2'h0)
		|=> bus_rdata == 32'h0) else $error("unmapped read not zero");
	a_in_sel_width: assert property (bus_rd && bus_addr <= 12'h05C |=> bus_rdata[31:4] == 28'h0)
		else $error("input selector wider than four bits");
	a_out_sel_width: assert property (bus_rd && bus_addr[11:7] == 5'h02 |=> bus_rdata[31:4] == 28'h0)
		else $error("output selector wider than four bits");
	a_cfg_fields: assert property (bus_rd && bus_addr == 12'h200 |=> (bus_rdata & 32'hFFFF_DFFF) == 32'h0)
		else $error("config register has stray bits");
	a_opt_fields: assert property (bus_rd && bus_addr == 12'h204 |=> (bus_rdata & 32'hDFFF_FFFF) == 32'h0)
		else $error("option word has stray bits");
	// Analog pins are never driven by the matrix or the port.
	a_analog_wins: assert property (|analog_sel |=> (pin_oe & $past(analog_sel)) == 32'h0)
		else $error("analog pin driven");
	// Nothing is routed straight after reset.
	a_reset_idle: assert property ($fell(sys_rst) |-> {spi1_slave_select, uart1_receive, ext_irq4_input} == 3'h6)
		else $error("peripheral input not idle after reset");
	a_reset_float: assert property ($fell(sys_rst) |=> pin_oe == $past(gpio_oe & ~analog_sel))
		else $error("remap drives a pin after reset");

	// Main scenarios reached.
	c_cfg_read: cover property (bus_rd && bus_addr == 12'h200);
	c_analog: cover property (|analog_sel);
	c_reset_exit: cover property ($fell(sys_rst));
endmodule

bind peripheral_pin_remap_lock remap_monitor u_mon (.clock, .sys_rst, .bus_addr, .bus_rd, .bus_rdata,
	.gpio_oe, .analog_sel, .pin_oe, .spi1_slave_select, .uart1_receive, .ext_irq4_input);

`default_nettype wire

// File: test_peripheral_pin_remap_lock.sv
// Purpose: Self-checking bench for the peripheral remap matrix.
// Assumes: Largest package, so every pin is present.
// Notes: Register calls are one-cycle strobes with a gap between them.
`timescale 1ns/1ns
`default_nettype none
`include "remap_defines.vh"

module test_peripheral_pin_remap_lock;
	logic clock, sys_rst, bus_wr, bus_rd, system_unlocked, one_way_fuse;
	logic [11:0] bus_addr;
	logic [31:0] bus_wdata, gpio_out, gpio_oe, analog_sel, pads, d;
	logic [15:0] s, e;
	wire [31:0] bus_rdata, pin_out, pin_oe, pi;
	wire [15:0] so;
	wire [23:0] q;
	int num_errors, n_checks, k, g, c, p;
	localparam logic [23:0] idle = `IN_IDLE;
	// Pin, code and source of each output selection; the last fourteen are reserved codes.
	logic [15:0] otab [32] = '{16'h0010, 16'h0021, 16'h0032, 16'h0053, 16'h0834, 16'h0845, 16'h0856,
		16'h0877, 16'h1034, 16'h1045, 16'h1058, 16'h1069, 16'h107A, 16'h181B, 16'h182C, 16'h184D,
		16'h185E, 16'h187F, 16'h0040, 16'h0060, 16'h0080, 16'h00F0, 16'h0810, 16'h0820, 16'h0860,
		16'h0880, 16'h1010, 16'h1020, 16'h1080, 16'h1830, 16'h1860, 16'h18F0};

	// ==========================================================
	// Block and its far side
	far_side_model far (.src_lv(s), .pad_lv(pads), .periph_out(so), .pad_in(pi));
	peripheral_pin_remap_lock uut (.clock, .sys_rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
		.system_unlocked, .one_way_fuse, .pin_in(pi), .gpio_out, .gpio_oe, .analog_sel, .pin_out, .pin_oe,
		.uart1_transmit(so[0]), .uart2_request_to_send(so[1]), .spi1_slave_select_out(so[2]),
		.compare_output1(so[3]), .spi1_data_out(so[4]), .spi2_data_out(so[5]), .compare_output2(so[6]),
		.comparator3_output(so[7]), .compare_output4(so[8]), .compare_output5(so[9]),
		.reference_clock_out(so[10]), .uart1_request_to_send(so[11]), .uart2_transmit(so[12]),
		.spi2_slave_select_out(so[13]), .compare_output3(so[14]), .comparator1_output(so[15]),
		.ext_irq4_input(q[0]), .timer2_clock_in(q[1]), .capture4_in(q[2]), .spi1_slave_select(q[3]),
		.reference_clock_in(q[4]), .ext_irq3_input(q[5]), .timer3_clock_in(q[6]), .capture3_in(q[7]),
		.uart1_clear_to_send(q[8]), .uart2_receive(q[9]), .spi1_data_in(q[10]), .ext_irq2_input(q[11]),
		.timer4_clock_in(q[12]), .capture1_in(q[13]), .capture5_in(q[14]), .uart1_receive(q[15]),
		.uart2_clear_to_send(q[16]), .spi2_data_in(q[17]), .compare_fault_b(q[18]), .ext_irq1_input(q[19]),
		.timer5_clock_in(q[20]), .capture2_in(q[21]), .spi2_slave_select(q[22]), .compare_fault_a(q[23]));

	// ==========================================================
	// Tasks
	// Each register call first meets a rising edge so the strobe is launched right after it.
	// The extra edge after each strobe keeps two strobes from landing in one time step.
	task automatic wr(input [11:0] a, input [31:0] v);
		@(posedge clock);
		bus_addr <= a;
		bus_wdata <= v;
		bus_wr <= 1'b1;
		@(posedge clock);
		bus_wr <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input [11:0] a, output [31:0] v);
		@(posedge clock);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clock);
		bus_rd <= 1'b0;
		#1 v = bus_rdata;
		@(posedge clock);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic chk(input string nm, input [31:0] seen, input [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic do_reset;
		sys_rst <= 1'b1;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// ==========================================================
	// Clock and watchdog
	always #2 clock = ~clock;
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		conclude;
	end

	// ==========================================================
	// Main sequence
	initial begin
		{clock, sys_rst, bus_wr, bus_rd, bus_addr, bus_wdata, analog_sel, gpio_out} = '0;
		{system_unlocked, one_way_fuse, gpio_oe, pads, s} = {2'h3, 32'h0, 32'h0, 16'h0};
		sys_rst = 1'b1;
		do_reset;
		rd(12'h000, d); chk("input sel reset", d, 32'hF);
		rd(12'h17C, d); chk("output sel reset", d, 32'h0);
		rd(12'h200, d); chk("lock reset", d, 32'h0);
		rd(12'h204, d); chk("one way default", d, 32'h2000_0000);
		rd(12'h060, d); chk("unmapped read", d, 32'h0);
		$display("test reset values done");
		// Each source alone, then every source but it, so only the named one can match; reserved codes get all sources, then none.
		for (k = 0; k < 32; k++) begin
			e = otab[k];
			wr({4'h1, e[13:8], 2'h0}, {28'h0, e[7:4]});
			s <= (k < 18) ? 16'h1 << e[3:0] : 16'hFFFF;
			settle(2);
			chk("pin drive", pin_out[e[13:8]], k < 18);
			chk("pin enable", pin_oe[e[13:8]], k < 18);
			s <= ~s;
			settle(2);
			chk("pin drive inverse", pin_out[e[13:8]], 1'b0);
		end
		wr(12'h100, 32'h1);
		s <= 16'hFFFF;
		analog_sel <= 32'h1;
		gpio_oe <= 32'hFFFF_FFFF;
		settle(2);
		chk("analog pin enable", pin_oe[0], 1'b0);
		analog_sel <= 32'h0;
		settle(2);
		chk("remap over port", pin_out[0], 1'b1);
		chk("port keeps pin", pin_oe[1], 1'b1);
		$display("test output routing done");
		// Each input picks a pin, then a reserved code must leave it idle.
		for (k = 0; k < 24; k++) begin
			g = (k < 5) ? 0 : (k < 11) ? 1 : (k < 19) ? 2 : 3;
			c = (k < 5) ? k + 2 : k % 8;
			p = 8 * g + c;
			wr(12'(k * 4), 32'(c));
			pads <= 32'h1 << p;
			settle(7);
			chk("routed high", q[k], 1'b1);
			pads <= ~(32'h1 << p);
			settle(7);
			chk("routed low", q[k], 1'b0);
			wr(12'(k * 4), (k < 5) ? 32'h7 : 32'h8);
			pads <= {32{~idle[k]}};
			settle(7);
			chk("reserved idle", q[k], idle[k]);
		end
		$display("test input routing done");
		system_unlocked <= 1'b0;
		wr(12'h200, 32'h2000);
		rd(12'h200, d); chk("lock without unlock", d, 32'h0);
		system_unlocked <= 1'b1;
		wr(12'h200, 32'h2000);
		rd(12'h200, d); chk("lock set", d, 32'h2000);
		wr(12'h104, 32'h5);
		rd(12'h104, d); chk("locked output sel", d, 32'h0);
		wr(12'h000, 32'h3);
		rd(12'h000, d); chk("locked input sel", d, 32'h7);
		wr(12'h200, 32'h0);
		rd(12'h200, d); chk("one way keeps lock", d, 32'h2000);
		one_way_fuse <= 1'b0;
		do_reset;
		rd(12'h200, d); chk("reset clears lock", d, 32'h0);
		rd(12'h100, d); chk("reset clears sel", d, 32'h0);
		rd(12'h204, d); chk("one way cleared", d, 32'h0);
		wr(12'h200, 32'h2000);
		wr(12'h200, 32'h0);
		rd(12'h200, d); chk("lock clears", d, 32'h0);
		wr(12'h104, 32'h3);
		rd(12'h104, d); chk("unlocked write", d, 32'h3);
		$display("test lock done");
		conclude;
	end
endmodule

`default_nettype wire
